// ---- src/tefl_defs.svh ----
// Constants of the telemetry extremes and fault log block
// Assumes inclusion by bare name from each design file
`ifndef TEFL_DEFS_SVH
`define TEFL_DEFS_SVH
// Reload values of the extreme trackers
`define TEFL_PEAK_INIT 16'h7c00
`define TEFL_MIN_INIT 16'h7bff
`define TEFL_VOUT_MIN_INIT 16'hffff
// Manager command codes
`define TEFL_CMD_STORE 8'hea
`define TEFL_CMD_RESTORE 8'heb
`define TEFL_CMD_CLEAR 8'hec
`define TEFL_CMD_STATUS 8'hed
`define TEFL_CMD_LOG 8'hee
// Status byte layout
`define TEFL_ST_EE 0
`define TEFL_ST_RAM 1
`define TEFL_ST_RSVD 6'h00
// Measurement kinds on the conversion port
`define TEFL_KIND_VOUT 2'h0
`define TEFL_KIND_IOUT 2'h1
`define TEFL_KIND_TEMP 2'h2
`define TEFL_KIND_VIN 2'h3
// Rolling log geometry
`define TEFL_LOG_AW 7
`define TEFL_LOG_BYTES 8'hff
`define TEFL_NCH 2
`endif

// ---- src/tefl_pkg.sv ----
// Types and helpers shared by the telemetry extremes and fault log block
// Assumes nothing of its surroundings
package tefl_pkg;
  // Fault log transfer engine states, Gray along idle-store-restore-erase
  typedef enum logic [1:0] {
    TEFL_IDLE = 2'h0,
    TEFL_STORE = 2'h1,
    TEFL_RESTORE = 2'h3,
    TEFL_ERASE = 2'h2
  } tefl_state_t;

  typedef logic signed [47:0] tefl_key_t;

  // Linear-11 word to a comparable fixed point key
  function automatic tefl_key_t tefl_l11_key(input logic [15:0] w);
    tefl_key_t m;
    logic [4:0] sh;
    m = {{37{w[10]}}, w[10:0]};
    sh = {~w[15], w[14:11]}; // Exponent plus sixteen
    return m <<< sh;
  endfunction
endpackage

// ---- src/tefl_extreme.sv ----
// Single peak or minimum tracker for one telemetry quantity
// Assumes samples arrive as one-cycle strobes on the same clock
`timescale 1ns/1ps
`include "tefl_defs.svh"
module tefl_extreme #(
  parameter logic [15:0] INIT = `TEFL_PEAK_INIT,
  parameter bit IS_MIN = 1'b0,
  parameter bit IS_UNS = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reload,
  input wire logic smp_vld,
  input wire logic [15:0] smp,
  output logic [15:0] val_reg
);
  logic [15:0] base;
  logic better;

  function automatic tefl_pkg::tefl_key_t key(input logic [15:0] w);
    return IS_UNS ? tefl_pkg::tefl_key_t'({32'h0000_0000, w}) : tefl_pkg::tefl_l11_key(w);
  endfunction

  // A reload in the sample cycle still lets the sample compete
  assign base = reload ? INIT : val_reg;
  assign better = IS_MIN ? (key(smp) < key(base)) : (key(smp) > key(base));

  // Extreme register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      val_reg <= INIT;
    end else if (smp_vld && better) begin
      val_reg <= smp; // RL20
    end else if (reload) begin
      val_reg <= INIT;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_track;
    smp_vld && !reload && better |=> val_reg == $past(smp);
  endproperty
  a_track: assert property (p_track) else $error("Extreme not replaced"); // RL20

  property p_keep;
    !reload && !(smp_vld && better) |=> $stable(val_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("Extreme changed unprompted"); // RL20
endmodule

// ---- src/tefl_log_ram.sv ----
// Rolling fault log buffer: one write port, two unclocked read ports
// Assumes the owner arbitrates writers onto the single write port
`timescale 1ns/1ps
`include "tefl_defs.svh"
module tefl_log_ram (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [`TEFL_LOG_AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [`TEFL_LOG_AW-1:0] ra_addr,
  output logic [15:0] ra_data,
  input wire logic [`TEFL_LOG_AW-1:0] rb_addr,
  output logic [15:0] rb_data
);
  logic [15:0] mem [0:(1<<`TEFL_LOG_AW)-1];

  // Word write
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Reads for the nonvolatile copy and for the host block read
  assign ra_data = mem[ra_addr];
  assign rb_data = mem[rb_addr];
endmodule

// ---- src/tefl_top.sv ----
// Telemetry extremes per channel plus a shared input voltage minimum, and fault log control
// Assumes a decoded command layer on MCLK and an external nonvolatile copy engine
//
// Contract
// RL1: Per-channel current peak, reload 0x7C00
// RL2: Per-channel temperature peak, reload 0x7C00
// RL3: Input voltage minimum, reload 0x7BFF on any
// RL4: Per-channel output voltage minimum, reload 0xFFFF
// RL5: Per-channel current minimum, reload 0x7BFF
// RL6: Per-channel temperature minimum, reload 0x7BFF
// RL7: Store command copies log into nonvolatile
// RL8: Restore copies back, locks until read
// RL9: Clear command erases, re-enables transfers
// RL10: Host checks restored bit before clear
// RL11: Status byte read, upper six zero
// RL12: Logged bit set after transfer, inhibits more
// RL13: Logged bit cleared only by clear command
// RL14: Restored bit set, cleared by full read
// RL15: Log bytes returned sequentially by block read
// RL16: Readings written into rolling buffer continuously
// RL17: Fault copies buffer to nonvolatile, locks
// RL18: Buffer updates only while logged bit clear
// RL19: Fault or store transfers when enabled, clear
// RL20: New result replaces peak or minimum
`timescale 1ns/1ps
`include "tefl_defs.svh"
module tefl_top (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic ADC_VALID,
  input wire logic ADC_CH,
  input wire logic [1:0] ADC_KIND,
  input wire logic [15:0] ADC_DATA,
  input wire logic [`TEFL_NCH-1:0] CH_ON,
  input wire logic [`TEFL_NCH-1:0] FAULT_OFF,
  input wire logic LOG_EN,
  input wire logic CLR_FAULTS,
  input wire logic CLR_PAGE,
  input wire logic SEND_STB,
  input wire logic [7:0] SEND_CODE,
  output logic SEND_ACK,
  output logic SEND_NACK,
  input wire logic RD_STB,
  input wire logic [7:0] RD_CODE,
  output logic [7:0] RD_DATA,
  output logic RD_ACK,
  output logic RD_NACK,
  input wire logic BLK_NEXT,
  output logic [7:0] BLK_DATA,
  output logic BLK_ACK,
  input wire logic BLK_DONE,
  output logic EE_REQ,
  output logic [1:0] EE_OP,
  input wire logic EE_ACK,
  input wire logic EE_FLAG_NV,
  input wire logic [`TEFL_LOG_AW-1:0] EE_RD_ADDR,
  output logic [15:0] EE_RD_DATA,
  input wire logic EE_WR_EN,
  input wire logic [`TEFL_LOG_AW-1:0] EE_WR_ADDR,
  input wire logic [15:0] EE_WR_DATA,
  output logic [`TEFL_LOG_AW-1:0] LOG_POS,
  output logic [7:0] FL_STATUS,
  output logic [`TEFL_NCH-1:0][15:0] IOUT_PEAK,
  output logic [`TEFL_NCH-1:0][15:0] IOUT_MIN,
  output logic [`TEFL_NCH-1:0][15:0] TEMP_PEAK,
  output logic [`TEFL_NCH-1:0][15:0] TEMP_MIN,
  output logic [`TEFL_NCH-1:0][15:0] VOUT_MIN,
  output logic [15:0] VIN_MIN
);
  tefl_pkg::tefl_state_t st_reg;
  tefl_pkg::tefl_state_t st_next;
  logic ee_bit_reg;
  logic ram_bit_reg;
  logic init_reg;
  logic fault_pend_reg;
  logic [`TEFL_NCH-1:0] ch_on_reg;
  logic [`TEFL_NCH-1:0] on_rise;
  logic [`TEFL_LOG_AW-1:0] wptr_reg;
  logic blk_act_reg;
  logic [7:0] blk_idx_reg;
  logic [15:0] blk_word;
  logic blk_ok;
  logic idle;
  logic cmd_store;
  logic cmd_restore;
  logic cmd_clear;
  logic xfer_ok;
  logic take_store;
  logic adc_wr;
  logic ram_wr;
  logic [`TEFL_LOG_AW-1:0] ram_addr;
  logic [15:0] ram_data;
  logic vin_reload;

  // Command decode and transfer permission
  assign idle = (st_reg == tefl_pkg::TEFL_IDLE);
  assign cmd_store = SEND_STB && (SEND_CODE == `TEFL_CMD_STORE);
  assign cmd_restore = SEND_STB && (SEND_CODE == `TEFL_CMD_RESTORE);
  assign cmd_clear = SEND_STB && (SEND_CODE == `TEFL_CMD_CLEAR);
  assign xfer_ok = LOG_EN && !ee_bit_reg; // RL12
  assign take_store = idle && xfer_ok &&
    (cmd_store || fault_pend_reg || ((|FAULT_OFF) && !SEND_STB)); // RL19

  // Off-to-on edge of each channel
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ch_on_reg <= '0;
    end else begin
      ch_on_reg <= CH_ON;
    end
  end
  assign on_rise = CH_ON & ~ch_on_reg;
  assign vin_reload = CLR_FAULTS || (|on_rise); // RL3

  // Extreme trackers, one set per channel
  genvar c;
  generate
    for (c = 0; c < `TEFL_NCH; c++) begin : g_ch
      logic rl;
      logic hit;
      assign rl = (CLR_FAULTS && (CLR_PAGE == c)) || on_rise[c]; // RL1
      assign hit = ADC_VALID && (ADC_CH == c);
      tefl_extreme #(.INIT(`TEFL_PEAK_INIT), .IS_MIN(1'b0), .IS_UNS(1'b0)) u_ipk (
        .mclk(MCLK), .rst_n(RST_N), .reload(rl),
        .smp_vld(hit && (ADC_KIND == `TEFL_KIND_IOUT)), .smp(ADC_DATA),
        .val_reg(IOUT_PEAK[c])); // RL1
      tefl_extreme #(.INIT(`TEFL_PEAK_INIT), .IS_MIN(1'b0), .IS_UNS(1'b0)) u_tpk (
        .mclk(MCLK), .rst_n(RST_N), .reload(rl),
        .smp_vld(hit && (ADC_KIND == `TEFL_KIND_TEMP)), .smp(ADC_DATA),
        .val_reg(TEMP_PEAK[c])); // RL2
      tefl_extreme #(.INIT(`TEFL_VOUT_MIN_INIT), .IS_MIN(1'b1), .IS_UNS(1'b1)) u_vmn (
        .mclk(MCLK), .rst_n(RST_N), .reload(rl),
        .smp_vld(hit && (ADC_KIND == `TEFL_KIND_VOUT)), .smp(ADC_DATA),
        .val_reg(VOUT_MIN[c])); // RL4
      tefl_extreme #(.INIT(`TEFL_MIN_INIT), .IS_MIN(1'b1), .IS_UNS(1'b0)) u_imn (
        .mclk(MCLK), .rst_n(RST_N), .reload(rl),
        .smp_vld(hit && (ADC_KIND == `TEFL_KIND_IOUT)), .smp(ADC_DATA),
        .val_reg(IOUT_MIN[c])); // RL5
      tefl_extreme #(.INIT(`TEFL_MIN_INIT), .IS_MIN(1'b1), .IS_UNS(1'b0)) u_tmn (
        .mclk(MCLK), .rst_n(RST_N), .reload(rl),
        .smp_vld(hit && (ADC_KIND == `TEFL_KIND_TEMP)), .smp(ADC_DATA),
        .val_reg(TEMP_MIN[c])); // RL6
    end
  endgenerate

  // Input voltage minimum, shared by all channels
  tefl_extreme #(.INIT(`TEFL_MIN_INIT), .IS_MIN(1'b1), .IS_UNS(1'b0)) u_vin (
    .mclk(MCLK), .rst_n(RST_N), .reload(vin_reload),
    .smp_vld(ADC_VALID && (ADC_KIND == `TEFL_KIND_VIN)), .smp(ADC_DATA),
    .val_reg(VIN_MIN)); // RL3

  // Buffer write arbitration: conversions when unlocked, copy engine on restore
  assign adc_wr = ADC_VALID && idle && !ee_bit_reg && !ram_bit_reg; // RL18
  assign ram_wr = (st_reg == tefl_pkg::TEFL_RESTORE) ? EE_WR_EN : adc_wr; // RL8
  assign ram_addr = (st_reg == tefl_pkg::TEFL_RESTORE) ? EE_WR_ADDR : wptr_reg;
  assign ram_data = (st_reg == tefl_pkg::TEFL_RESTORE) ? EE_WR_DATA : ADC_DATA;

  tefl_log_ram u_ram (
    .mclk(MCLK),
    .wr_en(ram_wr),
    .wr_addr(ram_addr),
    .wr_data(ram_data),
    .ra_addr(EE_RD_ADDR),
    .ra_data(EE_RD_DATA),
    .rb_addr(blk_idx_reg[`TEFL_LOG_AW:1]),
    .rb_data(blk_word)
  );

  // Rolling write pointer
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wptr_reg <= '0;
    end else if (adc_wr) begin
      wptr_reg <= wptr_reg + 1'b1; // RL16
    end
  end

  // Transfer engine next state
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      tefl_pkg::TEFL_IDLE: begin
        if (take_store) begin
          st_next = tefl_pkg::TEFL_STORE; // RL7
        end else if (cmd_restore) begin
          st_next = tefl_pkg::TEFL_RESTORE; // RL8
        end else if (cmd_clear) begin
          st_next = tefl_pkg::TEFL_ERASE; // RL9
        end
      end
      tefl_pkg::TEFL_STORE,
      tefl_pkg::TEFL_RESTORE,
      tefl_pkg::TEFL_ERASE: begin
        if (EE_ACK) begin
          st_next = tefl_pkg::TEFL_IDLE;
        end
      end
    endcase
  end

  // Transfer engine state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_reg <= tefl_pkg::TEFL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign EE_REQ = !idle;
  assign EE_OP = st_reg;

  // Latched-off faults wait here until the engine is free
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      fault_pend_reg <= 1'b0;
    end else if (take_store || !xfer_ok) begin
      fault_pend_reg <= 1'b0; // A starting store covers any fault of this cycle
    end else if (|FAULT_OFF) begin
      fault_pend_reg <= 1'b1; // RL17
    end
  end

  // Logged bit: nonvolatile copy loaded once after reset
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      init_reg <= 1'b0;
      ee_bit_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
      if (!init_reg) begin
        ee_bit_reg <= EE_FLAG_NV;
      end else if (st_reg == tefl_pkg::TEFL_STORE && EE_ACK) begin
        ee_bit_reg <= 1'b1; // RL12
      end else if (st_reg == tefl_pkg::TEFL_ERASE && EE_ACK) begin
        ee_bit_reg <= 1'b0; // RL13
      end
    end
  end

  // Restored bit: set wins over a read finishing in the same cycle
  assign blk_ok = BLK_DONE && blk_act_reg && (blk_idx_reg == `TEFL_LOG_BYTES);
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ram_bit_reg <= 1'b0;
    end else if (st_reg == tefl_pkg::TEFL_RESTORE && EE_ACK) begin
      ram_bit_reg <= 1'b1; // RL14
    end else if (blk_ok) begin
      ram_bit_reg <= 1'b0; // RL14
    end
  end
  assign FL_STATUS = {`TEFL_ST_RSVD, ram_bit_reg, ee_bit_reg}; // RL11
  assign LOG_POS = wptr_reg;

  // Send byte answers; busy engine or unknown code is refused
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SEND_ACK <= 1'b0;
      SEND_NACK <= 1'b0;
    end else begin
      SEND_ACK <= SEND_STB && idle && (cmd_store || cmd_restore || cmd_clear);
      SEND_NACK <= SEND_STB && !(idle && (cmd_store || cmd_restore || cmd_clear));
    end
  end

  // Read byte and block read start
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
      RD_ACK <= 1'b0;
      RD_NACK <= 1'b0;
    end else begin
      RD_ACK <= 1'b0;
      RD_NACK <= 1'b0;
      if (RD_STB && RD_CODE == `TEFL_CMD_STATUS) begin
        RD_DATA <= FL_STATUS; // RL11
        RD_ACK <= 1'b1;
      end else if (RD_STB && RD_CODE == `TEFL_CMD_LOG) begin
        RD_DATA <= `TEFL_LOG_BYTES; // RL15
        RD_ACK <= 1'b1;
      end else if (RD_STB) begin
        RD_NACK <= 1'b1;
      end
    end
  end

  // Sequential log bytes, low byte of each word first
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      blk_act_reg <= 1'b0;
      blk_idx_reg <= 8'h00;
      BLK_DATA <= 8'h00;
      BLK_ACK <= 1'b0;
    end else begin
      BLK_ACK <= BLK_NEXT && blk_act_reg;
      if (RD_STB && RD_CODE == `TEFL_CMD_LOG) begin
        blk_act_reg <= 1'b1;
        blk_idx_reg <= 8'h00;
      end else if (blk_ok) begin
        blk_act_reg <= 1'b0;
      end else if (BLK_NEXT && blk_act_reg) begin
        if (blk_idx_reg != `TEFL_LOG_BYTES) begin
          BLK_DATA <= blk_idx_reg[0] ? blk_word[15:8] : blk_word[7:0]; // RL15
          blk_idx_reg <= blk_idx_reg + 8'h01;
        end else begin
          BLK_DATA <= 8'h00;
        end
      end
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_store_done;
    st_reg == tefl_pkg::TEFL_STORE && EE_ACK && init_reg;
  endsequence
  sequence s_fault_seen;
    (|FAULT_OFF) && xfer_ok && idle && !SEND_STB && init_reg;
  endsequence

  property p_store_sets;
    s_store_done |=> ee_bit_reg ##1 ee_bit_reg;
  endproperty
  a_store_sets: assert property (p_store_sets) else $error("Logged bit not set"); // RL12

  property p_inhibit;
    idle && ee_bit_reg && cmd_store && init_reg |=> idle;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Store ran while logged"); // RL12

  property p_ee_hold;
    init_reg && ee_bit_reg && !(st_reg == tefl_pkg::TEFL_ERASE && EE_ACK) |=> ee_bit_reg;
  endproperty
  a_ee_hold: assert property (p_ee_hold) else $error("Logged bit lost"); // RL13

  property p_fault_store;
    s_fault_seen |=> st_reg == tefl_pkg::TEFL_STORE ##0 EE_REQ;
  endproperty
  a_fault_store: assert property (p_fault_store) else $error("Fault not stored"); // RL17

  property p_restore;
    idle && cmd_restore && !take_store |=> st_reg == tefl_pkg::TEFL_RESTORE;
  endproperty
  a_restore: assert property (p_restore) else $error("Restore not started"); // RL8

  property p_ram_lock;
    st_reg == tefl_pkg::TEFL_RESTORE && EE_ACK |=> ram_bit_reg ##0 $stable(wptr_reg);
  endproperty
  a_ram_lock: assert property (p_ram_lock) else $error("Restore did not lock"); // RL14

  property p_ram_hold;
    ram_bit_reg && !blk_ok |=> ram_bit_reg;
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("Restored bit lost"); // RL14

  property p_frozen;
    ee_bit_reg || ram_bit_reg |=> $stable(wptr_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Buffer moved while locked"); // RL18

  property p_erase;
    idle && cmd_clear && !take_store && !cmd_restore |=> st_reg == tefl_pkg::TEFL_ERASE;
  endproperty
  a_erase: assert property (p_erase) else $error("Clear not started"); // RL9

  property p_status;
    RD_STB && RD_CODE == `TEFL_CMD_STATUS |=> RD_ACK && RD_DATA == $past(FL_STATUS);
  endproperty
  a_status: assert property (p_status) else $error("Bad status answer"); // RL11

  property p_vin_reload;
    CLR_FAULTS && !ADC_VALID |=> VIN_MIN == `TEFL_MIN_INIT;
  endproperty
  a_vin_reload: assert property (p_vin_reload) else $error("Vin min not reloaded"); // RL3
endmodule

// ---- testbench/tefl_nv_model.sv ----
// Behavioural nonvolatile copy engine on the far side of the fault log block
// Assumes inputs driven from MCLK registers; answers one operation at a time
`timescale 1ns/1ps
`include "tefl_defs.svh"
module tefl_nv_model (
  input wire logic mclk,
  input wire logic ee_req,
  input wire logic [1:0] ee_op,
  input wire logic slow,
  output logic ee_ack,
  output logic flag_nv,
  output logic [`TEFL_LOG_AW-1:0] rd_addr,
  output logic wr_en,
  output logic [`TEFL_LOG_AW-1:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [1:0] op;
  int k;
  // Serve a request after a prompt or slow delay, then ack for one cycle
  initial begin
    ee_ack = 1'b0;
    flag_nv = 1'b0;
    rd_addr = '0;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    forever begin
      @(posedge mclk);
      #1;
      if (ee_req === 1'b1) begin
        op = ee_op;
        repeat (slow ? 20 : 2) @(posedge mclk);
        // Walk the whole buffer for store and restore
        for (k = 0; k < 128 && op != tefl_pkg::TEFL_ERASE; k++) begin
          #1;
          rd_addr = k[6:0];
          wr_en = (op == tefl_pkg::TEFL_RESTORE);
          wr_addr = k[6:0];
          wr_data = {8'h5a ^ k[7:0], k[7:0]};
          @(posedge mclk);
        end
        #1;
        wr_en = 1'b0;
        wr_data = ~wr_data; // Released bus shows no stale word
        ee_ack = 1'b1;
        if (op == tefl_pkg::TEFL_STORE) flag_nv = 1'b1;
        if (op == tefl_pkg::TEFL_ERASE) flag_nv = 1'b0;
        @(posedge mclk);
        #1;
        ee_ack = 1'b0;
      end
    end
  end
endmodule

// ---- testbench/tefl_top_bench.sv ----
// Self-checking bench of the telemetry extremes and fault log block
// Assumes tefl_top and tefl_nv_model are compiled before it
`timescale 1ns/1ps
`include "tefl_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tefl_top_bench;
  logic mclk, rst_n, adc_valid, adc_ch, log_en, clr_faults, clr_page, slow;
  logic [1:0] adc_kind, ch_on, fault_off, ee_op;
  logic [15:0] adc_data, vin_min, ee_rd_data, ee_wr_data;
  logic send_stb, send_ack, send_nack, rd_stb, rd_ack, rd_nack;
  logic [7:0] send_code, rd_code, rd_data, blk_data, fl_status, eb;
  logic blk_next, blk_ack, blk_done, ee_req, ee_ack, ee_flag_nv, ee_wr_en;
  logic [`TEFL_LOG_AW-1:0] ee_rd_addr, ee_wr_addr, log_pos, p;
  logic [`TEFL_NCH-1:0][15:0] iout_peak, iout_min, temp_peak, temp_min, vout_min;
  int n_fail, checks_done, i;

  tefl_top u_tefl_top (.MCLK(mclk), .RST_N(rst_n), .ADC_VALID(adc_valid), .ADC_CH(adc_ch),
    .ADC_KIND(adc_kind), .ADC_DATA(adc_data), .CH_ON(ch_on), .FAULT_OFF(fault_off),
    .LOG_EN(log_en), .CLR_FAULTS(clr_faults), .CLR_PAGE(clr_page), .SEND_STB(send_stb),
    .SEND_CODE(send_code), .SEND_ACK(send_ack), .SEND_NACK(send_nack), .RD_STB(rd_stb),
    .RD_CODE(rd_code), .RD_DATA(rd_data), .RD_ACK(rd_ack), .RD_NACK(rd_nack),
    .BLK_NEXT(blk_next), .BLK_DATA(blk_data), .BLK_ACK(blk_ack), .BLK_DONE(blk_done),
    .EE_REQ(ee_req), .EE_OP(ee_op), .EE_ACK(ee_ack), .EE_FLAG_NV(ee_flag_nv),
    .EE_RD_ADDR(ee_rd_addr), .EE_RD_DATA(ee_rd_data), .EE_WR_EN(ee_wr_en),
    .EE_WR_ADDR(ee_wr_addr), .EE_WR_DATA(ee_wr_data), .LOG_POS(log_pos),
    .FL_STATUS(fl_status), .IOUT_PEAK(iout_peak), .IOUT_MIN(iout_min),
    .TEMP_PEAK(temp_peak), .TEMP_MIN(temp_min), .VOUT_MIN(vout_min), .VIN_MIN(vin_min));

  tefl_nv_model u_tefl_nv_model (.mclk(mclk), .ee_req(ee_req), .ee_op(ee_op), .slow(slow),
    .ee_ack(ee_ack), .flag_nv(ee_flag_nv), .rd_addr(ee_rd_addr), .wr_en(ee_wr_en),
    .wr_addr(ee_wr_addr), .wr_data(ee_wr_data));

  // Free-running 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Inputs change a fixed 1 ns after each rising edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic adc(input logic ch, input logic [1:0] k, input logic [15:0] d);
    adc_valid = 1'b1;
    adc_ch = ch;
    adc_kind = k;
    adc_data = d;
    tick();
    adc_valid = 1'b0;
    tick();
  endtask

  task automatic send(input logic [7:0] c, input logic ack);
    send_code = c;
    send_stb = 1'b1;
    tick();
    send_stb = 1'b0;
    `CHK("send_ack", ack, send_ack)
    `CHK("send_nack", ~ack, send_nack)
    tick();
  endtask

  task automatic rd(input logic [7:0] c, input logic ack, input logic [7:0] d);
    rd_code = c;
    rd_stb = 1'b1;
    tick();
    rd_stb = 1'b0;
    `CHK("rd_ack", ack, rd_ack)
    `CHK("rd_nack", ~ack, rd_nack)
    if (ack) `CHK("rd_data", d, rd_data)
    tick();
  endtask

  // Bounded wait for the copy engine to go idle
  task automatic wait_idle();
    for (i = 0; i < 600 && ee_req !== 1'b0; i++) tick();
    if (ee_req !== 1'b0) begin
      n_fail++;
      $display("MISMATCH ee_req exp 0 got %b", ee_req);
      summarize();
    end
    tick();
  endtask

  task automatic pulse_reset();
    rst_n = 1'b0;
    repeat (5) tick();
    rst_n = 1'b1;
    repeat (2) tick();
  endtask

  task automatic check_init();
    for (int c = 0; c < 2; c++) begin
      `CHK("iout_peak", `TEFL_PEAK_INIT, iout_peak[c])
      `CHK("temp_peak", `TEFL_PEAK_INIT, temp_peak[c])
      `CHK("vout_min", `TEFL_VOUT_MIN_INIT, vout_min[c])
      `CHK("iout_min", `TEFL_MIN_INIT, iout_min[c])
      `CHK("temp_min", `TEFL_MIN_INIT, temp_min[c])
    end
    `CHK("vin_min", `TEFL_MIN_INIT, vin_min)
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    {rst_n, adc_valid, adc_ch, adc_kind, adc_data, fault_off} = '0;
    {clr_faults, clr_page, send_stb, send_code, rd_stb, rd_code} = '0;
    {blk_next, blk_done, slow} = '0;
    ch_on = 2'h3;
    log_en = 1'b1;
    pulse_reset();
    check_init();
    rd(`TEFL_CMD_STATUS, 1'b1, 8'h00);
    tend("reset");
    p = log_pos;
    adc(1'b0, `TEFL_KIND_IOUT, 16'h0010);
    adc(1'b0, `TEFL_KIND_IOUT, 16'h0008);
    adc(1'b1, `TEFL_KIND_TEMP, 16'h0020);
    adc(1'b1, `TEFL_KIND_TEMP, 16'h0030);
    adc(1'b0, `TEFL_KIND_VOUT, 16'h1234);
    adc(1'b0, `TEFL_KIND_VIN, 16'h0030);
    `CHK("iout_peak0", 16'h0010, iout_peak[0])
    `CHK("iout_min0", 16'h0008, iout_min[0])
    `CHK("temp_peak1", 16'h0030, temp_peak[1])
    `CHK("temp_min1", 16'h0020, temp_min[1])
    `CHK("vout_min0", 16'h1234, vout_min[0])
    `CHK("vin_min", 16'h0030, vin_min)
    `CHK("log_pos", p + 7'h06, log_pos)
    tend("extremes");
    clr_page = 1'b1;
    clr_faults = 1'b1;
    tick();
    clr_faults = 1'b0;
    tick();
    `CHK("temp_peak1", `TEFL_PEAK_INIT, temp_peak[1])
    `CHK("temp_min1", `TEFL_MIN_INIT, temp_min[1])
    `CHK("iout_peak0", 16'h0010, iout_peak[0])
    `CHK("vin_min", `TEFL_MIN_INIT, vin_min)
    ch_on = 2'h2;
    tick();
    ch_on = 2'h3;
    repeat (2) tick();
    `CHK("iout_peak0", `TEFL_PEAK_INIT, iout_peak[0])
    `CHK("iout_min0", `TEFL_MIN_INIT, iout_min[0])
    `CHK("vout_min0", `TEFL_VOUT_MIN_INIT, vout_min[0])
    tend("reloads");
    send(`TEFL_CMD_STORE, 1'b1);
    `CHK("ee_op", tefl_pkg::TEFL_STORE, ee_op)
    wait_idle();
    `CHK("status", 8'h01, fl_status)
    p = log_pos;
    adc(1'b0, `TEFL_KIND_IOUT, 16'h0040);
    `CHK("log_pos", p, log_pos)
    `CHK("iout_peak0", 16'h0040, iout_peak[0])
    send(`TEFL_CMD_STORE, 1'b1);
    `CHK("ee_req", 1'b0, ee_req)
    fault_off = 2'h1;
    tick();
    fault_off = 2'h0;
    tick();
    `CHK("ee_req", 1'b0, ee_req)
    send(8'he0, 1'b0);
    rd(8'h00, 1'b0, 8'h00);
    rd(`TEFL_CMD_STATUS, 1'b1, 8'h01);
    pulse_reset();
    check_init();
    `CHK("status", 8'h01, fl_status)
    tend("store");
    rd(`TEFL_CMD_STATUS, 1'b1, 8'h01);
    send(`TEFL_CMD_CLEAR, 1'b1);
    `CHK("ee_op", tefl_pkg::TEFL_ERASE, ee_op)
    wait_idle();
    `CHK("status", 8'h00, fl_status)
    slow = 1'b1;
    send(`TEFL_CMD_RESTORE, 1'b1);
    send(`TEFL_CMD_STORE, 1'b0);
    wait_idle();
    slow = 1'b0;
    `CHK("status", 8'h02, fl_status)
    p = log_pos;
    adc(1'b0, `TEFL_KIND_VOUT, 16'h0100);
    `CHK("log_pos", p, log_pos)
    tend("restore");
    rd(`TEFL_CMD_LOG, 1'b1, 8'hff);
    blk_next = 1'b1;
    for (int b = 0; b < 256; b++) begin
      tick();
      eb = (b == 255) ? 8'h00 : b[0] ? (8'h5a ^ {1'b0, b[7:1]}) : {1'b0, b[7:1]};
      `CHK("blk_ack", 1'b1, blk_ack)
      `CHK("blk_data", eb, blk_data)
    end
    blk_next = 1'b0;
    `CHK("status", 8'h02, fl_status)
    blk_done = 1'b1;
    tick();
    blk_done = 1'b0;
    tick();
    `CHK("status", 8'h00, fl_status)
    blk_next = 1'b1;
    tick();
    blk_next = 1'b0;
    `CHK("blk_ack", 1'b0, blk_ack)
    tend("block_read");
    p = log_pos;
    adc(1'b1, `TEFL_KIND_VOUT, 16'h0200);
    `CHK("log_pos", p + 7'h01, log_pos)
    log_en = 1'b0;
    fault_off = 2'h1;
    tick();
    fault_off = 2'h0;
    tick();
    `CHK("ee_req", 1'b0, ee_req)
    log_en = 1'b1;
    fault_off = 2'h2;
    tick();
    fault_off = 2'h0;
    repeat (2) tick();
    wait_idle();
    `CHK("status", 8'h01, fl_status)
    `CHK("ee_rd_data", 16'h257f, ee_rd_data)
    tend("fault");
    summarize();
  end
endmodule
